// *** src/ssr_defs.vh ***
// register map, field positions, reset values and frame constants
// assumes inclusion by the bank and its synchroniser only
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH

// register addresses (7-bit address field of a command)
`define SSR_ADDR_SWITCH 7'h01
`define SSR_ADDR_ERRCFG 7'h02
`define SSR_ADDR_ERRFLG 7'h03
`define SSR_ADDR_BURST 7'h05
`define SSR_ADDR_SRKEY 7'h0b
// address byte of the clear command; not a register
`define SSR_ADDR_CLEAR 7'h6c

// reset values
`define SSR_RST_SWITCH 4'h0
`define SSR_RST_ERRCFG 3'h6
`define SSR_RST_ERRFLG 3'h0
`define SSR_RST_BURST 1'h0
`define SSR_RST_SRKEY 8'h00

// error configuration and flag bit positions
`define SSR_BIT_RW 2
`define SSR_BIT_SCLK 1
`define SSR_BIT_CRC 0

// command layout: bit 15 read, bits 14:8 address, bits 7:0 data
`define SSR_CMD_RD_BIT 15
`define SSR_CLEAR_CMD 16'h6ca9
`define SSR_SR_KEY_ONE 8'ha3
`define SSR_SR_KEY_TWO 8'h05

// frame lengths and address and check edge counts in serial clock cycles
`define SSR_LEN_PLAIN 5'h10
`define SSR_LEN_CRC 5'h18
`define SSR_ADDR_EDGE 5'h07
`define SSR_CHECK_EDGE 5'h08

// crc-8 generator and seed
`define SSR_CRC_POLY 8'h07
`define SSR_CRC_SEED 8'h00

// synchroniser idle levels {sdi, cs_b, sclk}
`define SSR_SYNC_IDLE 3'h2

`endif

// *** src/ssr_sync.v ***
// three-stage synchroniser with agreement filter, one lane per bit
// assumes asynchronous pin inputs sampled on ref_clk
`timescale 1ns/1ps
`include "ssr_defs.vh"

module ssr_sync (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // pins in, filtered levels out
   input wire [2:0] pin_in,
   output wire [2:0] level_out
);

   // per-lane idle level, so reset does not fake a pin edge
   localparam [2:0] idle_lvl = `SSR_SYNC_IDLE;

   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_lane
         reg s1_r;
         reg s2_r;
         reg s3_r;
         reg lvl_r;
         always @(posedge ref_clk) begin
            if (!rst_b) begin
               s1_r <= idle_lvl[i];
               s2_r <= idle_lvl[i];
               s3_r <= idle_lvl[i];
               lvl_r <= idle_lvl[i];
            end else begin
               s1_r <= pin_in[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               // only a value held by both later stages counts
               if (s2_r == s3_r) begin
                  lvl_r <= s3_r;
               end
            end
         end
         assign level_out[i] = lvl_r;
      end
   endgenerate

endmodule // ssr_sync

// *** src/ssr_bank.v ***
// register bank behind the serial control port of a four-switch device
// assumes serial pins from an spi host (mode 0 or 3), ref_clk far faster
// than the serial clock
//
// Notes on behaviour
// - four switch enables in bits 3:0; one closes a switch, zero opens it
// - switch register reads zero after reset, all switches open
// - reserved bits read zero and writes cannot change them
// - error configuration resets to 0x06
// - each error detector has its own writable enable
// - bit 2 enables bad address detection, reset one
// - bit 1 enables clock count checking, reset one
// - no crc, no burst: exactly 16 clocks per frame
// - crc on, no burst: exactly 24 clocks per frame
// - no crc, burst: any multiple of 16 clocks per frame
// - crc on, burst: any multiple of 24 clocks per frame
// - bit 0 enables crc, reset zero; commands then grow to 24 bits
// - command 0x6ca9 with good crc clears all flags, no address error
// - bad or read-only address caught at ninth edge, write suppressed
// - writes of 0xa3 then 0x05 to key register restore all defaults
`timescale 1ns/1ps
`include "ssr_defs.vh"

module ssr_bank (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // serial port
   input wire sclk,
   input wire cs_b,
   input wire sdi,
   output reg sdo_r,
   output reg sdo_oe_r,
   // switch drives
   output wire switch_one_close,
   output wire switch_two_close,
   output wire switch_three_close,
   output wire switch_four_close
);

   wire [2:0] lvl;
   wire sclk_f;
   wire cs_f;
   wire sdi_f;
   reg sclk_q_r;
   reg cs_q_r;

   reg [3:0] sw_r;
   reg [2:0] cfg_r;
   reg [2:0] flg_r;
   reg burst_r;
   reg [7:0] srkey_r;
   reg key_armed_r;
   reg soft_rst_r;

   reg [4:0] bit_cnt_r;
   reg [23:0] shift_r;
   reg [7:0] crc_r;
   reg [1:0] cmd_n_r;
   reg addr_bad_r;
   reg [7:0] sdo_sh_r;

   ssr_sync u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .pin_in({sdi, cs_b, sclk}),
      .level_out(lvl)
   );

   assign sclk_f = lvl[0];
   assign cs_f = lvl[1];
   assign sdi_f = lvl[2];

   assign switch_one_close = sw_r[0];
   assign switch_two_close = sw_r[1];
   assign switch_three_close = sw_r[2];
   assign switch_four_close = sw_r[3];

   wire active = ~cs_f;
   wire rise = active & sclk_f & ~sclk_q_r;
   wire fall = active & ~sclk_f & sclk_q_r;
   wire frame_end = cs_f & ~cs_q_r;
   wire crc_en = cfg_r[`SSR_BIT_CRC];
   wire sclk_en = cfg_r[`SSR_BIT_SCLK];
   wire rw_en = cfg_r[`SSR_BIT_RW];
   // command length follows the crc enable
   wire [4:0] len = crc_en ? `SSR_LEN_CRC : `SSR_LEN_PLAIN;

   wire [23:0] sh_nxt = {shift_r[22:0], sdi_f};
   wire [4:0] cnt_inc = bit_cnt_r + 5'h01;
   wire done = rise & (cnt_inc == len);
   wire [15:0] cmd = crc_en ? sh_nxt[23:8] : sh_nxt[15:0];
   wire cmd_rd = cmd[`SSR_CMD_RD_BIT];
   wire [6:0] cmd_addr = cmd[14:8];
   wire [7:0] cmd_data = cmd[7:0];
   wire crc_good = ~crc_en | (sh_nxt[7:0] == crc_r);
   wire is_clear = (cmd == `SSR_CLEAR_CMD);
   wire wr_ok = done & crc_good & ~cmd_rd & ~addr_bad_r & ~is_clear;

   // serial crc over the 16 command bits
   wire crc_fb = crc_r[7] ^ sdi_f;
   wire [7:0] crc_step = {crc_r[6:0], 1'b0} ^ (crc_fb ? `SSR_CRC_POLY : 8'h00);

   // address byte as known after the eighth rising edge
   wire a_rd = sh_nxt[7];
   wire [6:0] a_addr = sh_nxt[6:0];
   reg a_valid;
   reg [7:0] rd_val;
   always @* begin
      a_valid = 1'b1;
      rd_val = 8'h00;
      case (a_addr)
         `SSR_ADDR_SWITCH: rd_val = {4'h0, sw_r};
         `SSR_ADDR_ERRCFG: rd_val = {5'h00, cfg_r};
         `SSR_ADDR_ERRFLG: begin
            rd_val = {5'h00, flg_r};
            a_valid = a_rd;
         end
         `SSR_ADDR_BURST: rd_val = {7'h00, burst_r};
         `SSR_ADDR_SRKEY: rd_val = srkey_r;
         // clear command target is not a register; a write to it is not flagged here but at the end unless it is 0x6ca9, a read is
         `SSR_ADDR_CLEAR: a_valid = ~a_rd;
         default: a_valid = 1'b0;
      endcase
   end

   // sclk count check: partial command, or more than one without burst
   wire count_bad = (bit_cnt_r != 5'h00) |
      (~burst_r & (cmd_n_r > 2'h1));

   // frame engine
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         sclk_q_r <= 1'b0;
         cs_q_r <= 1'b1;
         bit_cnt_r <= 5'h00;
         shift_r <= 24'h00_0000;
         crc_r <= `SSR_CRC_SEED;
         cmd_n_r <= 2'h0;
         addr_bad_r <= 1'b0;
         sdo_sh_r <= 8'h00;
         sdo_r <= 1'b0;
         sdo_oe_r <= 1'b0;
      end else begin
         sclk_q_r <= sclk_f;
         cs_q_r <= cs_f;
         sdo_oe_r <= active;
         if (!active) begin
            bit_cnt_r <= 5'h00;
            crc_r <= `SSR_CRC_SEED;
            cmd_n_r <= 2'h0;
            addr_bad_r <= 1'b0;
            sdo_sh_r <= 8'h00;
            sdo_r <= 1'b0;
         end else if (rise) begin
            shift_r <= sh_nxt;
            if (bit_cnt_r < `SSR_LEN_PLAIN) begin
               crc_r <= crc_step;
            end
            if (bit_cnt_r == `SSR_ADDR_EDGE) begin
               addr_bad_r <= ~a_valid;
               sdo_sh_r <= (a_rd & a_valid) ? rd_val : 8'h00;
            end
            if (done) begin
               bit_cnt_r <= 5'h00;
               crc_r <= `SSR_CRC_SEED;   // next burst command
               addr_bad_r <= 1'b0;
               if (cmd_n_r != 2'h3) begin
                  cmd_n_r <= cmd_n_r + 2'h1;
               end
            end else begin
               bit_cnt_r <= cnt_inc;
            end
         end else if (fall) begin
            // data leaves on falling edges, host samples on rising
            sdo_r <= sdo_sh_r[7];
            sdo_sh_r <= {sdo_sh_r[6:0], 1'b0};
         end
      end
   end

   // registers; soft reset restores every default
   always @(posedge ref_clk) begin
      if (!rst_b || soft_rst_r) begin
         sw_r <= `SSR_RST_SWITCH;
         cfg_r <= `SSR_RST_ERRCFG;
         flg_r <= `SSR_RST_ERRFLG;
         burst_r <= `SSR_RST_BURST;
         srkey_r <= `SSR_RST_SRKEY;
         key_armed_r <= 1'b0;
         soft_rst_r <= 1'b0;
      end else begin
         if (done) begin
            // key sequence must be two back-to-back commands
            key_armed_r <= wr_ok && cmd_addr == `SSR_ADDR_SRKEY &&
               cmd_data == `SSR_SR_KEY_ONE;
            soft_rst_r <= wr_ok && key_armed_r &&
               cmd_addr == `SSR_ADDR_SRKEY &&
               cmd_data == `SSR_SR_KEY_TWO;
            if (!crc_good) begin
               flg_r[`SSR_BIT_CRC] <= 1'b1;
            end else if (is_clear) begin
               flg_r <= 3'h0;
            end else if (cmd_addr == `SSR_ADDR_CLEAR && rw_en) begin
               flg_r[`SSR_BIT_RW] <= 1'b1;
            end
         end
         if (rise && bit_cnt_r == `SSR_CHECK_EDGE && addr_bad_r &&
               rw_en) begin
            flg_r[`SSR_BIT_RW] <= 1'b1;
         end
         if (frame_end && sclk_en && count_bad) begin
            flg_r[`SSR_BIT_SCLK] <= 1'b1;
         end
         if (wr_ok) begin
            case (cmd_addr)
               `SSR_ADDR_SWITCH: sw_r <= cmd_data[3:0];
               `SSR_ADDR_ERRCFG: cfg_r <= cmd_data[2:0];
               `SSR_ADDR_BURST: burst_r <= cmd_data[0];
               `SSR_ADDR_SRKEY: srkey_r <= cmd_data;
               default: sw_r <= sw_r;
            endcase
         end
      end
   end

endmodule // ssr_bank

// *** verification/ssr_bank_asserts.sv ***
// pin checker for the serial register bank
// assumes pins change on ref_clk falling edges
`timescale 1ns/1ps
module ssr_bank_asserts (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // serial port and switches
   input wire sclk,
   input wire cs_b,
   input wire sdi,
   input wire sdo_r,
   input wire sdo_oe_r,
   input wire switch_one_close,
   input wire switch_two_close,
   input wire switch_three_close,
   input wire switch_four_close
);
   wire [3:0] sw = {switch_four_close, switch_three_close,
      switch_two_close, switch_one_close};
   reg sclk_q, cs_q;
   reg [4:0] rise_n, ev_n;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // cycles since a serial edge, saturating so idle stays quiet
   always @(posedge ref_clk) begin
      sclk_q <= sclk;
      cs_q <= cs_b;
      if (!rst_b || (sclk && !sclk_q)) rise_n <= 5'h00;
      else if (rise_n != 5'h1f) rise_n <= rise_n + 5'h01;
      if (!rst_b || (!sclk && sclk_q) || cs_b != cs_q) ev_n <= 5'h00;
      else if (ev_n != 5'h1f) ev_n <= ev_n + 5'h01;
   end
   a_sw_after_edge: assert property ($changed(sw) |-> rise_n < 5'h0c)
      else $error("switch outputs moved away from a serial edge");
   a_sw_idle_still: assert property (
      (cs_b && !sclk) [*8] |=> $stable(sw))
      else $error("switch outputs moved while deselected");
   a_sw_reset_open: assert property ($rose(rst_b) |-> sw == 4'h0)
      else $error("switches not open after reset");
   a_oe_reset_low: assert property ($rose(rst_b) |-> !sdo_oe_r)
      else $error("output enable high after reset");
   a_oe_on_select: assert property ($fell(cs_b) |-> ##[2:8] sdo_oe_r)
      else $error("output enable late after select");
   a_oe_off_release: assert property (
      $rose(cs_b) |-> ##[2:8] !sdo_oe_r)
      else $error("output enable late after release");
   a_oe_idle_low: assert property (cs_b [*8] |-> !sdo_oe_r)
      else $error("output enable high while deselected");
   a_sdo_after_fall: assert property (
      $changed(sdo_r) |-> ev_n < 5'h0a)
      else $error("serial out moved away from a falling edge");
endmodule // ssr_bank_asserts

bind ssr_bank ssr_bank_asserts ssr_bank_asserts_i (.ref_clk(ref_clk),
   .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo_r(sdo_r),
   .sdo_oe_r(sdo_oe_r), .switch_one_close(switch_one_close),
   .switch_two_close(switch_two_close),
   .switch_three_close(switch_three_close),
   .switch_four_close(switch_four_close));

// *** verification/ssr_host.sv ***
// spi host model, mode 0, 400 ns serial clock, msb first
// assumes pins moved on ref_clk falling edges
`timescale 1ns/1ps
module ssr_host (
   // clock
   input wire ref_clk,
   // serial port
   output reg sclk,
   output reg cs_b,
   output reg sdi,
   input wire sdo_r
);
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      sdi = 1'b0;
   end
   // n bits from the top of w; rd holds bits 8..15 seen on sdo
   task xfer(input [47:0] w, input int n, output logic [7:0] rd);
      int i;
      rd = 8'h00;
      @(negedge ref_clk);
      cs_b = 1'b0;
      for (i = 0; i < n; i++) begin
         sdi = w[47 - i];
         repeat (4) @(negedge ref_clk);
         sclk = 1'b1;
         repeat (4) @(negedge ref_clk);
         if (i >= 8 && i < 16) rd = {rd[6:0], sdo_r};
         sclk = 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      cs_b = 1'b1;
      // released line must not keep a stale bit
      sdi = ~sdi;
      repeat (16) @(negedge ref_clk);
   endtask
endmodule // ssr_host

// *** verification/ssr_bank_test.sv ***
// self-checking bench for the serial register bank
// assumes ssr_bank with its bound checker and the ssr_host model
`timescale 1ns/1ps
module ssr_bank_test;
   reg ref_clk, rst_b;
   wire sclk, cs_b, sdi, sdo_r, sdo_oe_r;
   wire [3:0] sw;
   int err_count, tests_run;
   logic crc_on;
   logic [7:0] v;
   ssr_host ssr_host_i (.ref_clk(ref_clk), .sclk(sclk), .cs_b(cs_b),
      .sdi(sdi), .sdo_r(sdo_r));
   ssr_bank ssr_bank_i (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk),
      .cs_b(cs_b), .sdi(sdi), .sdo_r(sdo_r), .sdo_oe_r(sdo_oe_r),
      .switch_one_close(sw[0]), .switch_two_close(sw[1]),
      .switch_three_close(sw[2]), .switch_four_close(sw[3]));
   function automatic [7:0] crc8(input [15:0] d);
      int i;
      crc8 = 8'h00;
      for (i = 15; i >= 0; i--)
         crc8 = {crc8[6:0], 1'b0} ^ ((crc8[7] ^ d[i]) ? 8'h07 : 8'h00);
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task cmd(input [15:0] c, output logic [7:0] r);
      if (crc_on) ssr_host_i.xfer({c, crc8(c), 24'h00_0000}, 24, r);
      else ssr_host_i.xfer({c, 32'h0000_0000}, 16, r);
   endtask
   task wr(input [6:0] a, input [7:0] d);
      cmd({1'b0, a, d}, v);
   endtask
   task rd(input [6:0] a, input [7:0] exp);
      cmd({1'b1, a, 8'h00}, v);
      chk(v, exp);
   endtask
   task t_reset;
      chk({4'h0, sw}, 8'h00);
      rd(7'h01, 8'h00);
      rd(7'h02, 8'h06);
      rd(7'h03, 8'h00);
      rd(7'h05, 8'h00);
      rd(7'h0b, 8'h00);
      $display("reset values done");
   endtask
   task t_switch;
      wr(7'h01, 8'hf5);
      chk({4'h0, sw}, 8'h05);
      rd(7'h01, 8'h05);
      wr(7'h01, 8'h0a);
      chk({4'h0, sw}, 8'h0a);
      $display("switch writes done");
   endtask
   task t_addr;
      wr(7'h03, 8'h07);
      rd(7'h03, 8'h04);
      cmd(16'h6ca9, v);
      rd(7'h03, 8'h00);
      // read of a missing register answers zero and flags
      rd(7'h04, 8'h00);
      rd(7'h03, 8'h04);
      cmd(16'h6ca9, v);
      wr(7'h02, 8'h00);
      wr(7'h04, 8'h01);
      ssr_host_i.xfer({16'h0105, 32'h0000_0000}, 17, v);
      rd(7'h03, 8'h00);
      wr(7'h02, 8'h06);
      $display("address checks done");
   endtask
   task t_count;
      ssr_host_i.xfer({16'h0103, 32'h0000_0000}, 15, v);
      chk({4'h0, sw}, 8'h05);
      rd(7'h03, 8'h02);
      cmd(16'h6ca9, v);
      wr(7'h05, 8'h01);
      ssr_host_i.xfer({16'h0103, 16'h010c, 16'h0000}, 32, v);
      chk({4'h0, sw}, 8'h0c);
      rd(7'h03, 8'h00);
      ssr_host_i.xfer({16'h0103, 32'h0000_0000}, 24, v);
      rd(7'h03, 8'h02);
      cmd(16'h6ca9, v);
      wr(7'h05, 8'h00);
      $display("clock counts done");
   endtask
   task t_crc;
      wr(7'h02, 8'h07);
      crc_on = 1'b1;
      wr(7'h01, 8'h06);
      chk({4'h0, sw}, 8'h06);
      rd(7'h03, 8'h00);
      ssr_host_i.xfer({16'h0109, ~crc8(16'h0109), 24'h00_0000}, 24, v);
      chk({4'h0, sw}, 8'h06);
      rd(7'h03, 8'h01);
      cmd(16'h6ca9, v);
      rd(7'h03, 8'h00);
      ssr_host_i.xfer({16'h8300, 32'h0000_0000}, 16, v);
      rd(7'h03, 8'h02);
      cmd(16'h6ca9, v);
      // two crc commands in one burst frame, 48 clocks
      wr(7'h05, 8'h01);
      ssr_host_i.xfer({16'h0103, crc8(16'h0103), 16'h010c,
         crc8(16'h010c)}, 48, v);
      chk({4'h0, sw}, 8'h0c);
      rd(7'h03, 8'h00);
      wr(7'h05, 8'h00);
      wr(7'h02, 8'h06);
      crc_on = 1'b0;
      $display("crc frames done");
   endtask
   task t_soft;
      wr(7'h01, 8'h0f);
      wr(7'h0b, 8'ha3);
      wr(7'h0b, 8'h05);
      chk({4'h0, sw}, 8'h00);
      rd(7'h02, 8'h06);
      rd(7'h0b, 8'h00);
      $display("software reset done");
   endtask
   task test_done;
      $display("tests %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      rst_b = 1'b0;
      crc_on = 1'b0;
      err_count = 0;
      tests_run = 0;
      repeat (20) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_reset;
      t_switch;
      t_addr;
      t_count;
      t_crc;
      t_soft;
      test_done;
   end
   // about 50 frames of 170 cycles each, with wide margin
   initial begin
      #2_000_000;
      err_count++;
      test_done;
   end
endmodule // ssr_bank_test
